/* tb/amc_core_model.sv */
// analog core and output pin model that latches any contention
`timescale 1ns/1ps

module amc_core_model (
    input  wire clk_sys,
    input  wire rst,
    input  wire amp_enable,
    input  wire amp_output_pin_tristate,
    input  wire rail_high,
    input  wire rail_low,
    output reg  fault
);
    // sticky, so a one-cycle glitch is not lost before the bench looks
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            fault <= 1'b0;
        else if (amp_enable && !amp_output_pin_tristate)
            fault <= 1'b1;
        else if (rail_high && rail_low)
            fault <= 1'b1;
    end
endmodule

/* tb/amc_props.sv */
// concurrent checks on the amplifier control ports
`timescale 1ns/1ps
`include "amc_defs.vh"

module amc_props #(
    parameter       CH_W         = 4,
    parameter       PIN_W        = 3,
    parameter       GAIN_W       = 3,
    parameter [3:0] POS_PIN_CODE = 4'h0
) (
    input wire                     clk_sys,
    input wire                     rst,
    input wire                     wb_cyc_i,
    input wire                     wb_stb_i,
    input wire                     wb_we_i,
    input wire [4:0]               wb_adr_i,
    input wire [3:0]               wb_sel_i,
    input wire [31:0]              wb_dat_i,
    input wire [31:0]              wb_dat_o,
    input wire                     wb_ack_o,
    input wire                     amp_enable,
    input wire                     charge_pump_on,
    input wire                     amp_output_pin_tristate,
    input wire                     unity_fb,
    input wire                     inv_pin_connect,
    input wire                     rail_high,
    input wire                     rail_low,
    input wire                     ladder_connect,
    input wire [(1<<GAIN_W)-1:0]   ladder_tap,
    input wire [(1<<CH_W)-1:0]     pos_src,
    input wire [(1<<PIN_W)-1:0]    noninv_input_pin,
    input wire [(1<<CH_W)-1:0]     neg_src,
    input wire [(1<<PIN_W)-1:0]    inv_input_pin
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_en_wr;
        s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == `AMC_OFS_CTRL0 && wb_dat_i[7]);
    endsequence

    a_ack_follows: assert property (s_take |=> wb_ack_o) else $error("ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not idle");
    a_tri_with_en: assert property (amp_output_pin_tristate == amp_enable)
        else $error("pin driver not off");
    a_en_write_lat: assert property (s_en_wr |=> ##1 amp_enable)
        else $error("enable late");
    a_rail_excl: assert property (!(rail_high && rail_low))
        else $error("both rails");
    // outputs must be quiet when off so the core draws no power
    a_off_quiet: assert property (!amp_enable |-> !(rail_high || rail_low || unity_fb
        || ladder_connect || charge_pump_on) && pos_src == 0 && neg_src == 0)
        else $error("switch closed while off");
    a_tap_onehot: assert property (ladder_connect |-> $onehot(ladder_tap))
        else $error("tap not one-hot");
    a_tap_off: assert property (!ladder_connect |-> ladder_tap == 0)
        else $error("tap without ladder");
    a_unity_frees: assert property (unity_fb |-> neg_src == 0 && !inv_pin_connect
        && inv_input_pin == 0)
        else $error("inverting pin held");
    a_pos_onehot: assert property (amp_enable |-> $onehot(pos_src))
        else $error("positive source");
    a_pin_needs_ch: assert property (noninv_input_pin != 0 |-> pos_src[POS_PIN_CODE]
        && $onehot(noninv_input_pin))
        else $error("pin without channel");
endmodule

bind amc_top amc_props #(.CH_W(CH_W), .PIN_W(PIN_W), .GAIN_W(GAIN_W),
    .POS_PIN_CODE(POS_PIN_CODE)) u_props (.clk_sys(clk_sys), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .amp_enable(amp_enable), .charge_pump_on(charge_pump_on),
    .amp_output_pin_tristate(amp_output_pin_tristate), .unity_fb(unity_fb),
    .inv_pin_connect(inv_pin_connect), .rail_high(rail_high), .rail_low(rail_low),
    .ladder_connect(ladder_connect), .ladder_tap(ladder_tap), .pos_src(pos_src),
    .noninv_input_pin(noninv_input_pin), .neg_src(neg_src), .inv_input_pin(inv_input_pin));

/* tb/test_amp_mode_control.sv */
// self-checking bench for the amplifier mode control
`timescale 1ns/1ps
`include "amc_defs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module test_amp_mode_control;
    logic        clk_sys = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [4:0]  wb_adr_i = 0;
    logic [3:0]  wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, rd;
    logic [7:0]  override_src = 0, st;
    logic [15:0] lfsr = 16'h3191;
    logic [7:0]  r [6];
    logic [7:0]  msk [6] = '{8'hab, 8'h7f, 8'h0f, 8'h7f, 8'h33, 8'hc7};
    int          err_count = 0, n_compared = 0;
    wire [31:0]  wb_dat_o;
    wire         wb_ack_o, amp_enable, charge_pump_on, amp_output_pin_tristate, fault;
    wire         unity_fb, inv_pin_connect, rail_high, rail_low, ladder_connect;
    wire [7:0]   ladder_tap, noninv_input_pin, inv_input_pin;
    wire [15:0]  pos_src, neg_src;

    amc_top DUT (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .override_src, .amp_enable, .charge_pump_on,
        .amp_output_pin_tristate, .unity_fb, .inv_pin_connect, .rail_high, .rail_low,
        .ladder_connect, .ladder_tap, .pos_src, .noninv_input_pin, .neg_src,
        .inv_input_pin);
    amc_core_model u_core (.clk_sys, .rst, .amp_enable, .amp_output_pin_tristate,
        .rail_high, .rail_low, .fault);

    initial forever #2 clk_sys = ~clk_sys;
    // a full run needs about 2100 cycles
    initial
    begin
        #100000;
        err_count++;
        close_out;
    end

    function automatic logic [7:0] rnd();
        repeat (8) lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction

    function automatic logic [7:0] est();
        logic       f, u, rh, rl;
        logic [1:0] m;
        f = override_src[r[5][2:0]] ^ r[5][6];
        m = f ? r[4][5:4] : r[4][1:0];
        u = r[5][7] ? m == `AMC_HW_UNITY : r[0][3];
        rh = r[5][7] ? (m == `AMC_HW_RAIL) & f : r[0][1:0] == `AMC_SOC_HIGH_RAIL;
        rl = r[5][7] ? (m == `AMC_HW_RAIL) & !f : r[0][1:0] == `AMC_SOC_LOW_RAIL;
        return {r[0][7], f, {4{r[0][7]}} & {u, rh, rl, r[1][3]}, r[0][7], r[5][7]};
    endfunction

    task wb(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] s);
        @(posedge clk_sys);
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        wb_sel_i <= s;
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
    endtask

    task rchk(input logic [4:0] a, input logic [7:0] e);
        wb(0, a, 8'h00, 4'hf);
        `CHK(rd, {24'h0, e})
    endtask

    task close_out;
        $display("err_count=%0d n_compared=%0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst <= 0;
        // reset values, status and the unmapped word all read zero
        for (int a = 0; a < 8; a++) rchk(5'(a * 4), 8'h00);
        wb(1, `AMC_OFS_CTRL0, 8'h80, 4'he);
        rchk(`AMC_OFS_CTRL0, 8'h00);
        wb(1, `AMC_OFS_STATUS, 8'hff, 4'hf);
        rchk(`AMC_OFS_STATUS, 8'h00);
        wb(1, 5'h1c, 8'hff, 4'hf);
        rchk(5'h1c, 8'h00);
        for (int i = 0; i < 48; i++)
        begin
            foreach (r[j]) r[j] = rnd() & msk[j];
            // unity with a rail drive is left open, so keep them apart
            if (r[0][1] ^ r[0][0]) r[0][3] = 0;
            if (i < 4)
            begin
                r[0] = {1'b1, r[0][6:2], 2'(i)};
                r[5][7] = 0;
            end
            override_src <= rnd();
            foreach (r[j]) wb(1, 5'(j * 4), r[j] | ~msk[j], 4'h1);
            repeat (4) @(posedge clk_sys);
            foreach (r[j]) rchk(5'(j * 4), r[j]);
            st = est();
            rchk(`AMC_OFS_STATUS, st);
            `CHK(ladder_tap, st[2] ? 8'h1 << r[1][6:4] : 8'h0)
            `CHK(pos_src, st[7] ? 16'h1 << r[3][3:0] : 16'h0)
            `CHK(noninv_input_pin, (st[7] && !r[3][3:0]) ? 8'h1 << r[3][6:4] : 8'h0)
            `CHK(neg_src, (st[7] && !st[5]) ? 16'h1 << r[2][3:0] : 16'h0)
            `CHK(inv_input_pin, (st[7] && !st[5] && !r[2][3:0]) ? 8'h1 << r[1][2:0] : 8'h0)
            `CHK(inv_pin_connect, st[7] && !st[5] && !r[2][3:0])
            `CHK(charge_pump_on, r[0][7] & r[0][5])
        end
        `CHK(fault, 1'b0)
        // a second reset in mid-run must clear every register and switch
        rst <= 1;
        repeat (2) @(posedge clk_sys);
        rst <= 0;
        `CHK({amp_enable, ladder_tap, pos_src}, 25'h0)
        for (int a = 0; a < 8; a++)
            rchk(5'(a * 4), (a == 6) ? {1'b0, override_src[0], 6'h00} : 8'h00);
        close_out;
    end
endmodule

/* verilog/amc_defs.vh */
// register map, field positions, reset values and mode codes of the amplifier control
`ifndef AMC_DEFS_VH
`define AMC_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define AMC_OFS_CTRL0     5'h00
`define AMC_OFS_CTRL1     5'h04
`define AMC_OFS_NEGSEL    5'h08
`define AMC_OFS_POSSEL    5'h0c
`define AMC_OFS_HWMODE    5'h10
`define AMC_OFS_OVRIDE    5'h14
`define AMC_OFS_STATUS    5'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define AMC_CTRL0_EN      7
`define AMC_CTRL0_CPON    5
`define AMC_CTRL0_UG      3
`define AMC_CTRL0_SOC     1:0
`define AMC_CTRL1_GAIN    6:4
`define AMC_CTRL1_LADDER  3
`define AMC_CTRL1_NPIN    2:0
`define AMC_NEGSEL_CH     3:0
`define AMC_POSSEL_CH     3:0
`define AMC_POSSEL_PIN    6:4
`define AMC_HWMODE_HIGH   5:4
`define AMC_HWMODE_LOW    1:0
`define AMC_OVR_EN        7
`define AMC_OVR_INV       6
`define AMC_OVR_SRC       2:0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define AMC_RST_CTRL0     8'h00
`define AMC_RST_CTRL1     8'h00
`define AMC_RST_NEGSEL    8'h00
`define AMC_RST_POSSEL    8'h00
`define AMC_RST_HWMODE    8'h00
`define AMC_RST_OVRIDE    8'h00

// ----------------------------------------------------------------
// mode codes
// ----------------------------------------------------------------
`define AMC_SOC_BASIC     2'h0
`define AMC_SOC_LOW_RAIL  2'h1
`define AMC_SOC_HIGH_RAIL 2'h2
`define AMC_HW_BASIC      2'h0
`define AMC_HW_UNITY      2'h1
`define AMC_HW_RAIL       2'h2

`endif

/* verilog/amc_onehot.v */
// gated binary to one-hot decoder for the analog switch selects
`timescale 1ns/1ps

module amc_onehot #(
    parameter CW = 3
) (
    input  wire [CW-1:0]      code,
    input  wire               en,
    output wire [(1<<CW)-1:0] hot
);

    genvar i;
    generate
        for (i = 0; i < (1 << CW); i = i + 1)
        begin : g_dec
            // widen the code rather than slice the loop index
            assign hot[i] = en & ({{(32-CW){1'b0}}, code} == i);
        end
    endgenerate

endmodule

/* verilog/amc_sync.v */
// two flip-flop synchroniser for a group of level inputs
`timescale 1ns/1ps

module amc_sync #(
    parameter W = 8
) (
    input  wire         clk_sys,
    input  wire         rst,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

    reg [W-1:0] meta;

    // the first stage feeds only the second stage
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            meta <= {W{1'b0}};
            q    <= {W{1'b0}};
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

/* verilog/amc_top.v */
// amplifier mode control: wishbone registers, override logic and switch drive
//
// Operation
// - enabled amplifier tri-states output pin port driver
// - no override: software output control sets mode
// - unity select feeds output to inverting input
// - override: mode comes from hardware mode register
// - positive channel select picks noninverting source
// - positive pin select picks external noninverting pin
// - negative channel select picks inverting source
// - negative pin select picks external inverting pin
// - ladder connected only while ladder enable set
// - gain code selects ladder tap
// - override active only when enabled; source selectable
// - high signal uses high mode, low uses low
// - invert bit swaps which mode field applies
// - override offers basic, unity and rail drive
// - override rail follows signal and polarity
// - output control: basic, low rail, high rail
// - gain code 111 highest down to 000
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "amc_defs.vh"

module amc_top #(
    parameter NSRC         = 8,
    parameter SRC_W        = 3,
    parameter CH_W         = 4,
    parameter PIN_W        = 3,
    parameter GAIN_W       = 3,
    parameter [3:0] POS_PIN_CODE = 4'h0,
    parameter [3:0] NEG_PIN_CODE = 4'h0
) (
    input  wire                  clk_sys,
    input  wire                  rst,
    input  wire                  wb_cyc_i,
    input  wire                  wb_stb_i,
    input  wire                  wb_we_i,
    input  wire [4:0]            wb_adr_i,
    input  wire [3:0]            wb_sel_i,
    input  wire [31:0]           wb_dat_i,
    output reg  [31:0]           wb_dat_o,
    output reg                   wb_ack_o,
    input  wire [NSRC-1:0]       override_src,
    output reg                   amp_enable,
    output reg                   charge_pump_on,
    output reg                   amp_output_pin_tristate,
    output reg                   unity_fb,
    output reg                   inv_pin_connect,
    output reg                   rail_high,
    output reg                   rail_low,
    output reg                   ladder_connect,
    output reg  [(1<<GAIN_W)-1:0] ladder_tap,
    output reg  [(1<<CH_W)-1:0]  pos_src,
    output reg  [(1<<PIN_W)-1:0] noninv_input_pin,
    output reg  [(1<<CH_W)-1:0]  neg_src,
    output reg  [(1<<PIN_W)-1:0] inv_input_pin
);

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    reg  [7:0] ctrl0;
    reg  [7:0] ctrl1;
    reg  [7:0] negsel;
    reg  [7:0] possel;
    reg  [7:0] hwmode;
    reg  [7:0] ovride;
    wire [7:0] status;

    wire       bus_req;
    wire       wr_en;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // all fields sit in byte lane 0, the upper lanes are ignored
    assign wr_en   = bus_req & wb_we_i & wb_sel_i[0];

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ctrl0  <= `AMC_RST_CTRL0;
            ctrl1  <= `AMC_RST_CTRL1;
            negsel <= `AMC_RST_NEGSEL;
            possel <= `AMC_RST_POSSEL;
            hwmode <= `AMC_RST_HWMODE;
            ovride <= `AMC_RST_OVRIDE;
        end
        else if (wr_en)
        begin
            case (wb_adr_i)
                `AMC_OFS_CTRL0:
                begin
                    ctrl0 <= wb_dat_i[7:0] & 8'hab;
                end
                `AMC_OFS_CTRL1:
                begin
                    ctrl1 <= wb_dat_i[7:0] & 8'h7f;
                end
                `AMC_OFS_NEGSEL:
                begin
                    negsel <= wb_dat_i[7:0] & 8'h0f;
                end
                `AMC_OFS_POSSEL:
                begin
                    possel <= wb_dat_i[7:0] & 8'h7f;
                end
                `AMC_OFS_HWMODE:
                begin
                    hwmode <= wb_dat_i[7:0] & 8'h33;
                end
                `AMC_OFS_OVRIDE:
                begin
                    ovride <= wb_dat_i[7:0] & 8'hc7;
                end
                default:
                begin
                    ctrl0 <= ctrl0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // bus answer
    // ----------------------------------------------------------------
    reg [7:0] next_rdata;

    always @*
    begin
        case (wb_adr_i)
            `AMC_OFS_CTRL0:  next_rdata = ctrl0;
            `AMC_OFS_CTRL1:  next_rdata = ctrl1;
            `AMC_OFS_NEGSEL: next_rdata = negsel;
            `AMC_OFS_POSSEL: next_rdata = possel;
            `AMC_OFS_HWMODE: next_rdata = hwmode;
            `AMC_OFS_OVRIDE: next_rdata = ovride;
            `AMC_OFS_STATUS: next_rdata = status;
            default:         next_rdata = 8'h00;
        endcase
    end

    // one wait-free cycle: ack rises the edge after the request is seen
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i)
            begin
                wb_dat_o <= {24'h00_0000, next_rdata};
            end
            else
            begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // override source
    // ----------------------------------------------------------------
    // sources may come from peripherals on other clocks, so all pass
    // a synchroniser; this adds two cycles of mode switch latency
    wire [NSRC-1:0] src_sync;
    wire            ovr_on;
    wire            ovr_raw;
    wire            ovr_sig;
    wire [SRC_W-1:0] src_idx;

    amc_sync #(
        .W (NSRC)
    ) u_src_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       (override_src),
        .q       (src_sync)
    );

    assign src_idx = ovride[`AMC_OVR_SRC];
    assign ovr_on  = ovride[`AMC_OVR_EN];
    assign ovr_raw = src_sync[src_idx];
    assign ovr_sig = ovr_raw ^ ovride[`AMC_OVR_INV];

    // ----------------------------------------------------------------
    // mode resolution
    // ----------------------------------------------------------------
    reg [1:0] hw_mode;
    reg       next_unity;
    reg       next_rail_high;
    reg       next_rail_low;

    always @*
    begin
        hw_mode        = ovr_sig ? hwmode[`AMC_HWMODE_HIGH]
                                 : hwmode[`AMC_HWMODE_LOW];
        next_unity     = 1'b0;
        next_rail_high = 1'b0;
        next_rail_low  = 1'b0;
        if (ovr_on)
        begin
            case (hw_mode)
                `AMC_HW_UNITY:
                begin
                    next_unity = 1'b1;
                end
                `AMC_HW_RAIL:
                begin
                    next_rail_high = ovr_sig;
                    next_rail_low  = ~ovr_sig;
                end
                default:
                begin
                    next_unity = 1'b0;
                end
            endcase
        end
        else
        begin
            next_unity = ctrl0[`AMC_CTRL0_UG];
            case (ctrl0[`AMC_CTRL0_SOC])
                `AMC_SOC_LOW_RAIL:
                begin
                    next_rail_low = 1'b1;
                end
                `AMC_SOC_HIGH_RAIL:
                begin
                    next_rail_high = 1'b1;
                end
                default:
                begin
                    next_rail_low = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // source, pin and ladder selection
    // ----------------------------------------------------------------
    wire                  en;
    wire                  ladder_on;
    wire [CH_W-1:0]       positive_channel_select;
    wire [CH_W-1:0]       negative_channel_select;
    wire                  pos_ext;
    wire                  neg_ext;
    wire [(1<<CH_W)-1:0]  pos_hot;
    wire [(1<<CH_W)-1:0]  neg_hot;
    wire [(1<<PIN_W)-1:0] ppin_hot;
    wire [(1<<PIN_W)-1:0] npin_hot;
    wire [(1<<GAIN_W)-1:0] tap_hot;

    assign en        = ctrl0[`AMC_CTRL0_EN];
    assign ladder_on = en & ctrl1[`AMC_CTRL1_LADDER];
    assign positive_channel_select       = possel[CH_W-1:0];
    assign negative_channel_select       = negsel[CH_W-1:0];
    assign pos_ext   = (positive_channel_select == POS_PIN_CODE[CH_W-1:0]);
    // a unity-gain inverting input leaves the external pin free
    assign neg_ext   = (negative_channel_select == NEG_PIN_CODE[CH_W-1:0]) & ~next_unity;

    // ladder routing to either input is just a channel code
    amc_onehot #(
        .CW (CH_W)
    ) u_pos_ch (
        .code (positive_channel_select),
        .en   (en),
        .hot  (pos_hot)
    );

    amc_onehot #(
        .CW (CH_W)
    ) u_neg_ch (
        .code (negative_channel_select),
        .en   (en & ~next_unity),
        .hot  (neg_hot)
    );

    amc_onehot #(
        .CW (PIN_W)
    ) u_pos_pin (
        .code (possel[6:4]),
        .en   (en & pos_ext),
        .hot  (ppin_hot)
    );

    amc_onehot #(
        .CW (PIN_W)
    ) u_neg_pin (
        .code (ctrl1[`AMC_CTRL1_NPIN]),
        .en   (en & neg_ext),
        .hot  (npin_hot)
    );

    // tap index follows the code: highest code is highest gain
    amc_onehot #(
        .CW (GAIN_W)
    ) u_tap (
        .code (ctrl1[`AMC_CTRL1_GAIN]),
        .en   (ladder_on),
        .hot  (tap_hot)
    );

    // ----------------------------------------------------------------
    // registered switch drive
    // ----------------------------------------------------------------
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            amp_enable              <= 1'b0;
            charge_pump_on          <= 1'b0;
            amp_output_pin_tristate <= 1'b0;
            unity_fb                <= 1'b0;
            inv_pin_connect         <= 1'b0;
            rail_high               <= 1'b0;
            rail_low                <= 1'b0;
            ladder_connect          <= 1'b0;
            ladder_tap              <= {(1<<GAIN_W){1'b0}};
            pos_src                 <= {(1<<CH_W){1'b0}};
            noninv_input_pin        <= {(1<<PIN_W){1'b0}};
            neg_src                 <= {(1<<CH_W){1'b0}};
            inv_input_pin           <= {(1<<PIN_W){1'b0}};
        end
        else
        begin
            amp_enable              <= en;
            charge_pump_on          <= en & ctrl0[`AMC_CTRL0_CPON];
            amp_output_pin_tristate <= en;
            unity_fb                <= en & next_unity;
            inv_pin_connect         <= en & neg_ext;
            rail_high               <= en & next_rail_high;
            rail_low                <= en & next_rail_low;
            ladder_connect          <= ladder_on;
            ladder_tap              <= tap_hot;
            pos_src                 <= pos_hot;
            noninv_input_pin        <= ppin_hot;
            neg_src                 <= neg_hot;
            inv_input_pin           <= npin_hot;
        end
    end

    // ----------------------------------------------------------------
    // status view
    // ----------------------------------------------------------------
    assign status = {amp_enable, ovr_sig, unity_fb, rail_high,
                     rail_low, ladder_connect, amp_output_pin_tristate,
                     ovr_on};

endmodule
